// >>> logic/alu_pkg.sv
package alu_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int unsigned ADDR_W   = 8;
   localparam logic [7:0]  CTRL_OFS = 8'h00;
   localparam logic [7:0]  SRC_OFS  = 8'h04;
   localparam logic [7:0]  DST_OFS  = 8'h08;
   localparam logic [7:0]  FLAG_OFS = 8'h0c;
   localparam logic [7:0]  RES_OFS  = 8'h10;
   localparam logic [7:0]  STAT_OFS = 8'h14;
   localparam logic [7:0]  DISP_OFS = 8'h18;
   localparam logic [7:0]  BASE_OFS = 8'h1c;

   // ****************************************
   // reset values and status fields
   // ****************************************
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [15:0] WORD_RST    = 16'h0000;
   localparam logic [7:0]  FLAG_RST    = 8'h00;
   localparam int unsigned STAT_DONE   = 0;
   localparam int unsigned STAT_BAD    = 1;
   localparam int unsigned STAT_STORED = 2;

   // ****************************************
   // operations and destinations
   // ****************************************
   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_SEL  = 2'b01,
      OP_SUB  = 2'b10,
      OP_TEST = 2'b11
   } op_e;

   typedef enum logic [2:0] {
      DK_GEN_LO = 3'b000,
      DK_GEN_HI = 3'b001,
      DK_STATIC = 3'b010,
      DK_FRAME  = 3'b011,
      DK_ABS    = 3'b100
   } dest_kind_e;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic        start;
      logic [19:0] rsv_hi;
      dest_kind_e  dest_kind;
      logic        same_reg;
      logic        short_fmt;
      logic        dst_is_addr;
      logic        src_is_addr;
      logic        word;
      logic        rsv_lo;
      op_e         op;
   } ctrl_s;

   typedef struct packed {
      logic u;
      logic i;
      logic o;
      logic b;
      logic s;
      logic z;
      logic d;
      logic c;
   } flags_s;

   typedef struct packed {
      logic        valid;
      logic        to_reg;
      logic        high_byte;
      logic [15:0] addr;
      logic [7:0]  data;
   } store_s;

endpackage

// >>> logic/cond_select_sub_test_alu.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - the zero-select store writes the first immediate when Z is 1 and the second when Z is 0.
// - the select store takes 8-bit immediates; targets are gen reg 0 low/high, base+disp8, abs16.
// - subtract computes destination minus source and writes it back at byte or word size.
// - byte subtract into an address register zero-extends the source and works at 16 bits.
// - byte subtract from an address register uses only that register's low 8 bits.
// - the test operation widens its operands exactly as the subtract does.
// - subtract sets O when the signed result leaves the range of its width, else clears it.
// - subtract and test set S from the result's most significant bit.
// - subtract and test set Z when the result is zero, else clear it.
// - subtract sets C when no borrow occurs and clears it on a borrow.
// - the short subtract form is accepted at byte size only.
// - test forms the AND of both operands; it updates the flags and the result register, not the destination.
module cond_select_sub_test_alu (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   // apb slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // store port of the select store
   output alu_pkg::store_s        store_o,
   // flag register view
   output alu_pkg::flags_s        flags_o
);

   // ****************************************
   // registers and bus decode
   // ****************************************
   alu_pkg::ctrl_s    ctrl_q;
   logic [15:0]       src_q;
   logic [15:0]       dst_q;
   alu_pkg::flags_s   flags_q;
   logic [15:0]       res_q;
   logic [2:0]        stat_q;
   logic [15:0]       disp_q;
   logic [15:0]       static_base_q;
   logic [15:0]       frame_base_q;
   alu_pkg::store_s   store_q;
   logic              pready_q;
   logic              pslverr_q;
   logic [31:0]       prdata_q;
   logic              setup;
   logic              wr;
   logic              hit;
   logic              exec;
   alu_pkg::ctrl_s    cw;
   logic [31:0]       rd_mux;

   assign setup = psel_i & ~penable_i;
   assign wr    = psel_i & penable_i & pready_q & pwrite_i & hit;
   assign cw    = alu_pkg::ctrl_s'(pwdata_i);
   assign exec  = wr & (paddr_i == alu_pkg::CTRL_OFS) & cw.start;

   always_comb begin
      hit    = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr_i)
         alu_pkg::CTRL_OFS: rd_mux = 32'(ctrl_q);
         alu_pkg::SRC_OFS:  rd_mux = {16'h0000, src_q};
         alu_pkg::DST_OFS:  rd_mux = {16'h0000, dst_q};
         alu_pkg::FLAG_OFS: rd_mux = {24'h00_0000, flags_q};
         alu_pkg::RES_OFS:  rd_mux = {16'h0000, res_q};
         alu_pkg::STAT_OFS: rd_mux = {29'h0000_0000, stat_q};
         alu_pkg::DISP_OFS: rd_mux = {16'h0000, disp_q};
         alu_pkg::BASE_OFS: rd_mux = {frame_base_q, static_base_q};
         default:           hit    = 1'b0;
      endcase
   end

   // one wait-free access phase: answer is prepared during setup
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~hit;
         if (setup) prdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
   end

   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;
   assign prdata_o  = prdata_q;

   // ****************************************
   // datapath
   // ****************************************
   logic [15:0]       a16;
   logic [15:0]       b16;
   logic              wide;
   logic [16:0]       diff16;
   logic [8:0]        diff8;
   logic [15:0]       res;
   logic              res_msb;
   logic              res_zero;
   logic              ovf;
   logic              invalid;
   alu_pkg::flags_s   nflags;
   logic [7:0]        sel_val;
   logic [15:0]       eff_addr;

   always_comb begin
      b16  = cw.word ? src_q : {8'h00, src_q[7:0]};
      a16  = (cw.word | cw.dst_is_addr) ? dst_q : {8'h00, dst_q[7:0]};
      wide = cw.word | cw.dst_is_addr;
      diff16 = {1'b0, a16} - {1'b0, b16};
      diff8  = {1'b0, a16[7:0]} - {1'b0, b16[7:0]};
      res = (cw.op == alu_pkg::OP_SUB) ? (wide ? diff16[15:0] : {8'h00, diff8[7:0]})
                                        : (a16 & b16);
      res_msb  = wide ? res[15] : res[7];
      res_zero = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
      ovf = wide ? ((a16[15] ^ b16[15]) & (a16[15] ^ res[15]))
                 : ((a16[7] ^ b16[7]) & (a16[7] ^ res[7]));
   end

   always_comb begin
      invalid = 1'b0;
      if (!cw.word && cw.src_is_addr && cw.dst_is_addr &&
          (cw.op == alu_pkg::OP_SUB || cw.op == alu_pkg::OP_TEST)) invalid = 1'b1;
      if (cw.op == alu_pkg::OP_SUB && cw.short_fmt && cw.word) invalid = 1'b1;
      if (cw.op == alu_pkg::OP_SUB && cw.short_fmt && cw.same_reg) invalid = 1'b1;
      if (cw.op == alu_pkg::OP_SEL && cw.dest_kind > alu_pkg::DK_ABS) invalid = 1'b1;
   end

   always_comb begin
      nflags = flags_q;
      case (cw.op)
         alu_pkg::OP_SUB: begin
            nflags.s = res_msb;
            nflags.z = res_zero;
            nflags.o = ovf;
            nflags.c = wide ? ~diff16[16] : ~diff8[8];
         end
         alu_pkg::OP_TEST: begin
            nflags.s = res_msb;
            nflags.z = res_zero;
         end
         default: nflags = flags_q;
      endcase
   end

   assign sel_val = flags_q.z ? src_q[7:0] : src_q[15:8];

   // base-relative displacements are unsigned 8-bit
   always_comb begin
      case (cw.dest_kind)
         alu_pkg::DK_STATIC: eff_addr = static_base_q + {8'h00, disp_q[7:0]};
         alu_pkg::DK_FRAME:  eff_addr = frame_base_q + {8'h00, disp_q[7:0]};
         alu_pkg::DK_ABS:    eff_addr = disp_q;
         default:            eff_addr = 16'h0000;
      endcase
   end

   // ****************************************
   // software registers
   // ****************************************
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_q        <= alu_pkg::ctrl_s'(alu_pkg::CTRL_RST);
         src_q         <= alu_pkg::WORD_RST;
         disp_q        <= alu_pkg::WORD_RST;
         static_base_q <= alu_pkg::WORD_RST;
         frame_base_q  <= alu_pkg::WORD_RST;
      end else if (wr) begin
         case (paddr_i)
            alu_pkg::CTRL_OFS: begin
               ctrl_q       <= cw;
               ctrl_q.start <= 1'b0;
            end
            alu_pkg::SRC_OFS:  src_q <= pwdata_i[15:0];
            alu_pkg::DISP_OFS: disp_q <= pwdata_i[15:0];
            alu_pkg::BASE_OFS: begin
               static_base_q <= pwdata_i[15:0];
               frame_base_q  <= pwdata_i[31:16];
            end
            default: src_q <= src_q;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dst_q <= alu_pkg::WORD_RST;
      end else if (wr && paddr_i == alu_pkg::DST_OFS) begin
         dst_q <= pwdata_i[15:0];
      end else if (exec && !invalid && cw.op == alu_pkg::OP_SUB) begin
         dst_q <= wide ? res : {dst_q[15:8], res[7:0]};
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flags_q <= alu_pkg::flags_s'(alu_pkg::FLAG_RST);
      end else if (wr && paddr_i == alu_pkg::FLAG_OFS) begin
         flags_q <= alu_pkg::flags_s'(pwdata_i[7:0]);
      end else if (exec && !invalid) begin
         flags_q <= nflags;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         res_q <= alu_pkg::WORD_RST;
      end else if (exec && !invalid && cw.op != alu_pkg::OP_NONE) begin
         res_q <= (cw.op == alu_pkg::OP_SEL) ? {8'h00, sel_val} : res;
      end
   end

   // sticky status: a new event wins over a write-one clear
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stat_q <= 3'h0;
      end else begin
         if (wr && paddr_i == alu_pkg::STAT_OFS) stat_q <= stat_q & ~pwdata_i[2:0];
         if (exec) stat_q[alu_pkg::STAT_DONE] <= 1'b1;
         if (exec && invalid) stat_q[alu_pkg::STAT_BAD] <= 1'b1;
         if (exec && !invalid && cw.op == alu_pkg::OP_SEL) stat_q[alu_pkg::STAT_STORED] <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         store_q <= '0;
      end else if (exec && !invalid && cw.op == alu_pkg::OP_SEL) begin
         // byte immediate to reg or memory
         store_q.valid     <= 1'b1;
         store_q.to_reg    <= (cw.dest_kind == alu_pkg::DK_GEN_LO) ||
                              (cw.dest_kind == alu_pkg::DK_GEN_HI);
         store_q.high_byte <= (cw.dest_kind == alu_pkg::DK_GEN_HI);
         store_q.addr      <= eff_addr;
         store_q.data      <= sel_val;
      end else begin
         store_q.valid <= 1'b0;
      end
   end

   assign store_o = store_q;
   assign flags_o = flags_q;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_go_sel;
      exec && !invalid && cw.op == alu_pkg::OP_SEL;
   endsequence
   sequence s_go_sub;
      exec && !invalid && cw.op == alu_pkg::OP_SUB;
   endsequence
   sequence s_go_test;
      exec && !invalid && cw.op == alu_pkg::OP_TEST;
   endsequence

   property p_sel_pick;
      s_go_sel |=> store_q.valid && store_q.data ==
         ($past(flags_q.z) ? $past(src_q[7:0]) : $past(src_q[15:8])) ##1 !store_q.valid;
   endproperty
   a_sel_pick: assert property (p_sel_pick) else $error("select store wrong value");
   property p_sel_reg;
      s_go_sel ##0 cw.dest_kind == alu_pkg::DK_GEN_HI |=> store_q.to_reg && store_q.high_byte;
   endproperty
   a_sel_reg: assert property (p_sel_reg) else $error("select store wrong target");
   property p_sub_word;
      s_go_sub ##0 cw.word |=> dst_q == $past(dst_q) - $past(src_q);
   endproperty
   a_sub_word: assert property (p_sub_word) else $error("word difference wrong");
   property p_sub_ext;
      s_go_sub ##0 !cw.word && cw.dst_is_addr |=> dst_q == $past(dst_q) - {8'h00, $past(src_q[7:0])};
   endproperty
   a_sub_ext: assert property (p_sub_ext) else $error("zero-extended subtract wrong");
   property p_sub_low;
      s_go_sub ##0 !cw.word && !cw.dst_is_addr |=> dst_q[7:0] == 8'($past(dst_q[7:0]) -
         $past(src_q[7:0])) && dst_q[15:8] == $past(dst_q[15:8]);
   endproperty
   a_sub_low: assert property (p_sub_low) else $error("byte subtract wrong");
   property p_sub_ovf;
      s_go_sub ##0 cw.word && !src_q[15] && dst_q == 16'h8000 && src_q != 16'h0000
         |=> flags_q.o && !flags_q.s;
   endproperty
   a_sub_ovf: assert property (p_sub_ovf) else $error("overflow not flagged");
   property p_test_sign;
      s_go_test ##0 cw.word |=> flags_q.s == ($past(src_q[15]) && $past(dst_q[15]));
   endproperty
   a_test_sign: assert property (p_test_sign) else $error("test sign wrong");
   property p_sub_zero;
      s_go_sub ##0 cw.word && src_q == dst_q |=> flags_q.z && flags_q.c && dst_q == 16'h0000;
   endproperty
   a_sub_zero: assert property (p_sub_zero) else $error("equal operands flags wrong");
   property p_sub_borrow;
      s_go_sub ##0 cw.word && src_q > dst_q |=> !flags_q.c && !flags_q.z;
   endproperty
   a_sub_borrow: assert property (p_sub_borrow) else $error("borrow not shown");
   property p_short_word;
      exec && cw.op == alu_pkg::OP_SUB && cw.short_fmt && cw.word
         |=> stat_q[alu_pkg::STAT_BAD] && $stable(dst_q) && $stable(flags_q);
   endproperty
   a_short_word: assert property (p_short_word) else $error("short word form accepted");
   property p_test_keep;
      s_go_test |=> $stable(dst_q) && $stable(src_q) && flags_q.o == $past(flags_q.o)
         && flags_q.c == $past(flags_q.c);
   endproperty
   a_test_keep: assert property (p_test_keep) else $error("test disturbed state");

endmodule

// >>> tb/cond_select_sub_test_alu_bench.sv
`timescale 1ns/1ps
module cond_select_sub_test_alu_bench;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic              clk_i     = 1'b0;
   logic              sys_rst_i = 1'b1;
   logic              psel_i    = 1'b0;
   logic              penable_i = 1'b0;
   logic              pwrite_i  = 1'b0;
   logic [7:0]        paddr_i   = 8'h00;
   logic [31:0]       pwdata_i  = 32'h0000_0000;
   logic [31:0]       prdata_o;
   logic              pready_o;
   logic              pslverr_o;
   alu_pkg::store_s   store_o;
   alu_pkg::flags_s   flags_o;
   int                n_mismatch = 0;
   int                cmp_count  = 0;
   int                cycles     = 0;
   int                st_cnt     = 0;
   int                n0;
   alu_pkg::store_s   st_last;
   logic [31:0]       rdat;
   logic              rerr;
   logic [7:0]        f0;
   logic [39:0]       e;
   logic [15:0]       m;

   // sub cases first, then and-test cases; ctrl holds op, size and widening bits
   localparam logic [31:0] TC [12] = '{32'h0a, 32'h0a, 32'h0a, 32'h02, 32'h02, 32'h22,
      32'h12, 32'h42, 32'h0b, 32'h03, 32'h23, 32'h13};
   localparam logic [15:0] TD [12] = '{16'h8000, 16'h0005, 16'h0000, 16'h1234, 16'h0080,
      16'h0100, 16'h0010, 16'h7f05, 16'hffff, 16'h12f0, 16'h8100, 16'h0080};
   localparam logic [15:0] TS [12] = '{16'h0001, 16'h0005, 16'h0001, 16'h0035, 16'h0001,
      16'hff01, 16'hab20, 16'h0003, 16'h8000, 16'h0f0f, 16'hff00, 16'h8040};
   localparam logic [31:0] TB [5] = '{32'h32, 32'h33, 32'h4a, 32'hc2, 32'h501};

   cond_select_sub_test_alu dut (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .pwdata_i  (pwdata_i),
      .prdata_o  (prdata_o),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .store_o   (store_o),
      .flags_o   (flags_o)
   );

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // mid-cycle sampling keeps the pulse count free of edge races
   always @(negedge clk_i) begin
      if (store_o.valid === 1'b1) begin
         st_cnt++;
         st_last = store_o;
      end
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // outputs are read right after the edge, before its updates land: the values it sampled
   // only the bench timeout ends a wait for pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic op(input logic [31:0] c);
      wr(alu_pkg::CTRL_OFS, 32'h8000_0000 | c);
   endtask

   // returns {flags, new destination, result}
   function automatic logic [39:0] ref_op(input logic [31:0] c, input logic [15:0] d,
                                          input logic [15:0] s, input logic [7:0] f);
      logic        w16;
      logic [15:0] sx;
      logic [15:0] r;
      logic [15:0] nd;
      logic [7:0]  nf;
      w16 = c[3] | c[5];
      sx = c[3] ? s : {8'h00, s[7:0]};
      nf = f;
      nd = d;
      r = (c[1:0] == 2'd2) ? d - sx : d & sx;
      if (!w16) begin
         r[15:8] = 8'h00;
      end
      nf[3] = w16 ? r[15] : r[7];
      nf[2] = (r == 16'h0000);
      if (c[1:0] == 2'd2) begin
         nf[0] = w16 ? (d >= sx) : (d[7:0] >= s[7:0]);
         nf[5] = w16 ? (d[15] != sx[15] && r[15] != d[15]) : (d[7] != s[7] && r[7] != d[7]);
         nd = w16 ? r : {d[15:8], r[7:0]};
      end
      return {nf, nd, r};
   endfunction

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      chk("flags_o reset", {24'h0, flags_o}, 32'h0);
      rd(alu_pkg::FLAG_OFS);
      chk("flags reset", rdat, 32'h0);
      rd(alu_pkg::DST_OFS);
      chk("dst reset", rdat, 32'h0);
      rd(8'h20);
      chk("unmapped err", {31'h0, rerr}, 32'h1);
      chk("unmapped data", rdat, 32'h0);

      for (int i = 0; i < 12; i++) begin
         f0 = i[0] ? 8'hf1 : 8'h0e;
         e = ref_op(TC[i], TD[i], TS[i], f0);
         m = (TC[i][3] | TC[i][5]) ? 16'hffff : 16'h00ff;
         wr(alu_pkg::DST_OFS, {16'h0, TD[i]});
         wr(alu_pkg::SRC_OFS, {16'h0, TS[i]});
         wr(alu_pkg::FLAG_OFS, {24'h0, f0});
         op(TC[i]);
         rd(alu_pkg::DST_OFS);
         chk("dst", rdat, {16'h0, e[31:16]});
         rd(alu_pkg::RES_OFS);
         chk("result", rdat & {16'h0, m}, {16'h0, e[15:0] & m});
         chk("flags", {24'h0, flags_o}, {24'h0, e[39:32]});
         rd(alu_pkg::STAT_OFS);
         chk("status", {30'h0, rdat[1:0]}, 32'h1);
         wr(alu_pkg::STAT_OFS, 32'h7);
      end

      wr(alu_pkg::RES_OFS, 32'h0000_ffff);
      rd(alu_pkg::RES_OFS);
      chk("result ro", rdat, {16'h0, e[15:0]});

      wr(alu_pkg::BASE_OFS, 32'h2000_ff20);
      wr(alu_pkg::DISP_OFS, 32'h0000_12f0);
      wr(alu_pkg::SRC_OFS, 32'h0000_3ca5);
      for (int k = 0; k < 5; k++) begin
         for (int z = 0; z < 2; z++) begin
            f0 = z[0] ? 8'h04 : 8'hfb;
            wr(alu_pkg::FLAG_OFS, {24'h0, f0});
            n0 = st_cnt;
            op({21'h0, k[2:0], 8'h01});
            rd(alu_pkg::STAT_OFS);
            chk("store status", rdat, 32'h5);
            chk("store count", st_cnt - n0, 32'h1);
            chk("store data", {24'h0, st_last.data}, z[0] ? 32'ha5 : 32'h3c);
            chk("store reg", {30'h0, st_last.to_reg, st_last.high_byte},
                {30'h0, k < 2, k == 1});
            if (k > 1) begin
               chk("store addr", {16'h0, st_last.addr},
                   k == 2 ? 32'h0010 : (k == 3 ? 32'h20f0 : 32'h12f0));
            end
            chk("select flags", {24'h0, flags_o}, {24'h0, f0});
         end
      end

      wr(alu_pkg::DST_OFS, 32'h0000_1111);
      wr(alu_pkg::SRC_OFS, 32'h0000_2222);
      wr(alu_pkg::FLAG_OFS, 32'h0000_0055);
      for (int i = 0; i < 5; i++) begin
         wr(alu_pkg::STAT_OFS, 32'h7);
         n0 = st_cnt;
         op(TB[i]);
         rd(alu_pkg::DST_OFS);
         chk("refused dst", rdat, 32'h1111);
         chk("refused flags", {24'h0, flags_o}, 32'h55);
         chk("refused store", st_cnt - n0, 32'h0);
         rd(alu_pkg::STAT_OFS);
         chk("refused status", {30'h0, rdat[1:0]}, 32'h3);
      end
      wr(alu_pkg::STAT_OFS, 32'h7);
      rd(alu_pkg::STAT_OFS);
      chk("status clear", rdat, 32'h0);
      wrap_up();
   end
endmodule
